// file: devl_params.svh
// register offsets, field positions and reset values of the event latch block
`ifndef DEVL_PARAMS_SVH
`define DEVL_PARAMS_SVH
// global range byte offsets
`define DEVL_OFF_STAT 12'h000
`define DEVL_OFF_LATCH_LO 12'h010
`define DEVL_OFF_LATCH_HI 12'h014
`define DEVL_OFF_CLR_LO 12'h018
`define DEVL_OFF_CLR_HI 12'h01c
`define DEVL_OFF_SET_LO 12'h020
`define DEVL_OFF_SET_HI 12'h024
`define DEVL_OFF_SETP_LO 12'h028
`define DEVL_OFF_SETP_HI 12'h02c
`define DEVL_OFF_EN_LO 12'h030
`define DEVL_OFF_EN_HI 12'h034
`define DEVL_OFF_MISS_LO 12'h038
`define DEVL_OFF_MISS_HI 12'h03c
`define DEVL_OFF_MCLR_LO 12'h040
`define DEVL_OFF_MCLR_HI 12'h044
`define DEVL_OFF_RAE_LO 12'h048
`define DEVL_OFF_RAE_HI 12'h04c
`define DEVL_OFF_IEN 12'h050
`define DEVL_OFF_ISTAT 12'h054
`define DEVL_OFF_ICLR 12'h058
// shadow range: same layout, offset by this base
`define DEVL_SHADOW_BASE 12'h800
// status field positions
`define DEVL_ST_WRESP 3
`define DEVL_ST_XFER 2
`define DEVL_ST_QEVT 1
`define DEVL_ST_CEVT 0
// interrupt status bit raised by a new miss
`define DEVL_IRQ_MISS 4
// reset values
`define DEVL_RST_WORD 32'h0000_0000
`define DEVL_RST_CHAN 64'h0000_0000_0000_0000
`endif

// file: devl_pkg.sv
// types shared by the event latch block
package devl_pkg;
   typedef logic [63:0] devl_chan_t;
   typedef struct packed
   {
      logic valid;
      logic [5:0] chan;
   } devl_svc_t;
   typedef struct packed
   {
      logic wresp_busy;
      logic xfer_busy;
      logic quick_pend;
   } devl_act_t;
endpackage

// file: devl_pick.sv
// lowest-numbered pending channel picker
`timescale 1ns/1ps
`default_nettype none
module devl_pick
(
   // pending bitmap
   input wire logic [63:0] pend,
   // chosen channel
   output devl_pkg::devl_svc_t pick
);
   // fixed priority: channel 0 wins, simple and cheap for 64 inputs
   always_comb
   begin
      pick = '0;
      for (int i = 63; i >= 0; i--)
      begin
         if (pend[i])
         begin
            pick.valid = 1'b1;
            pick.chan = 6'(i);
         end
      end
   end
endmodule
`default_nettype wire

// file: devl_top.sv
// channel event latch, enable, miss and activity status with apb access
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "devl_params.svh"
module devl_top
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // external events, one pulse per event
   input wire logic [63:0] ext_event,
   // chained events raised by completion logic
   input wire logic [63:0] chain_event,
   // activity from neighbouring logic
   input wire devl_pkg::devl_act_t act_in,
   // service handshake toward prioritisation
   output devl_pkg::devl_svc_t svc_req,
   input wire logic svc_ack,
   // interrupt
   output logic irq
);

   // ****************************************
   // state
   // ****************************************
   // channel vectors, bit index is the channel number
   devl_pkg::devl_chan_t latch_r;
   devl_pkg::devl_chan_t en_r;
   devl_pkg::devl_chan_t miss_r;
   devl_pkg::devl_chan_t setp_r;
   devl_pkg::devl_chan_t chain_r;
   devl_pkg::devl_chan_t rae_r;
   logic [31:0] stat_r;
   logic [31:0] ien_r;
   logic [31:0] istat_r;
   // decode strobes and next values
   devl_pkg::devl_svc_t pick;
   devl_pkg::devl_chan_t pend;
   devl_pkg::devl_chan_t wmask;
   devl_pkg::devl_chan_t clr_w;
   devl_pkg::devl_chan_t set_w;
   devl_pkg::devl_chan_t mclr_w;
   devl_pkg::devl_chan_t svc_clr;
   devl_pkg::devl_chan_t miss_nxt;
   logic [31:0] rdata_nxt;
   logic err_nxt;
   logic wr_acc;
   logic rd_acc;
   logic shadow;
   logic [11:0] off;
   logic [31:0] evt_nxt;
   logic [31:0] iclr_w;
   logic [31:0] irq_src;

   // ****************************************
   // apb decode
   // ****************************************
   // one wait state: taken in the first access cycle, pready the next
   // gating with pready keeps a held access from landing twice
   assign wr_acc = psel & penable & pwrite & ~pready;
   assign rd_acc = psel & penable & ~pwrite & ~pready;
   assign shadow = paddr >= `DEVL_SHADOW_BASE;
   assign off = shadow ? paddr - `DEVL_SHADOW_BASE : paddr;

   // shadow accesses only reach channels the region enable allows
   always_comb
   begin
      wmask = '1;
      if (shadow)
         wmask = rae_r;
   end

   // write strobes, decoded per word into 64-bit channel vectors
   // a shadow write reaches only the channels its region may touch
   always_comb
   begin
      clr_w = '0;
      set_w = '0;
      mclr_w = '0;
      if (wr_acc)
      begin
         case (off)
            `DEVL_OFF_CLR_LO: clr_w[31:0] = pwdata;
            `DEVL_OFF_CLR_HI: clr_w[63:32] = pwdata;
            `DEVL_OFF_SET_LO: set_w[31:0] = pwdata;
            `DEVL_OFF_SET_HI: set_w[63:32] = pwdata;
            `DEVL_OFF_MCLR_LO: mclr_w[31:0] = pwdata;
            `DEVL_OFF_MCLR_HI: mclr_w[63:32] = pwdata;
            default: ;
         endcase
      end
      clr_w = clr_w & wmask;
      set_w = set_w & wmask;
      mclr_w = mclr_w & wmask;
   end

   // ****************************************
   // event pending and service
   // ****************************************
   // latched needs enable; software set and chained events do not
   assign pend = (latch_r & en_r) | setp_r | chain_r;

   // lowest channel first; a busy low channel can starve higher ones
   devl_pick i_devl_pick
   (
      .pend(pend),
      .pick(pick)
   );

   // service clears on the acked channel only
   always_comb
   begin
      svc_clr = '0;
      if (svc_ack & svc_req.valid)
         svc_clr[svc_req.chan] = 1'b1;
   end

   // request stays stable until acked, then re-evaluated next cycle
   // the idle cycle after an ack lets the cleared bit leave the pick
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         svc_req <= '0;
      else if (svc_ack | ~svc_req.valid)
         svc_req <= (svc_ack & svc_req.valid) ? '0 : pick;
   end

   // ****************************************
   // latch, set, chain and miss
   // ****************************************
   // set beats any clear in the same cycle; no direct writes reach it
   // an event and a clear together keep the bit, so no event is dropped
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         latch_r <= `DEVL_RST_CHAN;
      else
         latch_r <= ext_event | (latch_r & ~clr_w & ~svc_clr);
   end

   // software set pending, independent of the enable bits
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         setp_r <= `DEVL_RST_CHAN;
      else
         setp_r <= set_w | (setp_r & ~clr_w & ~svc_clr);
   end

   // chained events leave only by service, software clear leaves them
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         chain_r <= `DEVL_RST_CHAN;
      else
         chain_r <= chain_event | (chain_r & ~svc_clr);
   end

   // miss: new event on a latched enabled bit, even when cleared alongside
   assign miss_nxt = ext_event & latch_r & en_r;

   // miss bits stay until cleared; a new miss beats its clear
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         miss_r <= `DEVL_RST_CHAN;
      else
         miss_r <= miss_nxt | (miss_r & ~mclr_w);
   end

   // ****************************************
   // plain control registers
   // ****************************************
   // enable writes touch only the bits the addressed range may reach
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         en_r <= `DEVL_RST_CHAN;
      else if (wr_acc && off == `DEVL_OFF_EN_LO)
         en_r[31:0] <= (pwdata & wmask[31:0])
            | (en_r[31:0] & ~wmask[31:0]);
      else if (wr_acc && off == `DEVL_OFF_EN_HI)
         en_r[63:32] <= (pwdata & wmask[63:32])
            | (en_r[63:32] & ~wmask[63:32]);
   end

   // region enables only from the global range, else shadow could open itself
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         rae_r <= `DEVL_RST_CHAN;
      else if (wr_acc && !shadow && off == `DEVL_OFF_RAE_LO)
         rae_r[31:0] <= pwdata;
      else if (wr_acc && !shadow && off == `DEVL_OFF_RAE_HI)
         rae_r[63:32] <= pwdata;
   end

   // interrupt enable, global range only
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         ien_r <= `DEVL_RST_WORD;
      else if (wr_acc && !shadow && off == `DEVL_OFF_IEN)
         ien_r <= pwdata;
   end

   // ****************************************
   // activity status
   // ****************************************
   // raw activity bits, registered below so status reads are glitch free
   always_comb
   begin
      evt_nxt = '0;
      evt_nxt[`DEVL_ST_WRESP] = act_in.wresp_busy;
      evt_nxt[`DEVL_ST_XFER] = act_in.xfer_busy | svc_req.valid;
      evt_nxt[`DEVL_ST_QEVT] = act_in.quick_pend;
      evt_nxt[`DEVL_ST_CEVT] = |pend;
   end

   // status runs one cycle behind its sources
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         stat_r <= `DEVL_RST_WORD;
      else
         stat_r <= evt_nxt;
   end

   // ****************************************
   // interrupt: sticky on rising activity and on misses
   // ****************************************
   // sources: rising status bits and any new miss
   always_comb
   begin
      irq_src = '0;
      irq_src[3:0] = evt_nxt[3:0] & ~stat_r[3:0];
      irq_src[`DEVL_IRQ_MISS] = |miss_nxt;
   end

   // clear strobe, write-only and reachable from the global range only
   always_comb
   begin
      iclr_w = '0;
      if (wr_acc && !shadow && off == `DEVL_OFF_ICLR)
         iclr_w = pwdata;
   end

   // a write-one clear loses to a set in the same cycle
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         istat_r <= `DEVL_RST_WORD;
      else
         istat_r <= irq_src | (istat_r & ~iclr_w);
   end

   // level interrupt, one cycle behind the status that raised it
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= |(istat_r & ien_r);
   end

   // ****************************************
   // read mux and response
   // ****************************************
   // read mux; shadow reads of channel registers other than the region enables see only the channels their range allows
   always_comb
   begin
      rdata_nxt = '0;
      err_nxt = 1'b0;
      case (off)
         `DEVL_OFF_STAT: rdata_nxt = stat_r;
         `DEVL_OFF_LATCH_LO: rdata_nxt = latch_r[31:0] & wmask[31:0];
         `DEVL_OFF_LATCH_HI: rdata_nxt = latch_r[63:32] & wmask[63:32];
         `DEVL_OFF_SETP_LO: rdata_nxt = setp_r[31:0] & wmask[31:0];
         `DEVL_OFF_SETP_HI: rdata_nxt = setp_r[63:32] & wmask[63:32];
         `DEVL_OFF_EN_LO: rdata_nxt = en_r[31:0] & wmask[31:0];
         `DEVL_OFF_EN_HI: rdata_nxt = en_r[63:32] & wmask[63:32];
         `DEVL_OFF_MISS_LO: rdata_nxt = miss_r[31:0] & wmask[31:0];
         `DEVL_OFF_MISS_HI: rdata_nxt = miss_r[63:32] & wmask[63:32];
         `DEVL_OFF_RAE_LO: rdata_nxt = rae_r[31:0];
         `DEVL_OFF_RAE_HI: rdata_nxt = rae_r[63:32];
         `DEVL_OFF_IEN: rdata_nxt = ien_r;
         // interrupt status only reads; its clear sits at its own offset
         `DEVL_OFF_ISTAT: rdata_nxt = istat_r;
         // write-only registers are accepted and read as zero
         `DEVL_OFF_CLR_LO, `DEVL_OFF_CLR_HI, `DEVL_OFF_SET_LO,
         `DEVL_OFF_SET_HI, `DEVL_OFF_MCLR_LO, `DEVL_OFF_MCLR_HI,
         `DEVL_OFF_ICLR: ;
         default: err_nxt = 1'b1;
      endcase
   end

   // answer one cycle into the access phase
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         pready <= 1'b0;
         prdata <= `DEVL_RST_WORD;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & err_nxt;
         // read data moves only on a read, a write leaves the last value
         if (rd_acc)
            prdata <= err_nxt ? 32'h0 : rdata_nxt;
      end
   end

endmodule
`default_nettype wire

// file: devl_assertions.sv
// port checker for the event latch block
`timescale 1ns/1ps
`default_nettype none
`include "devl_params.svh"
module devl_assertions
(
   // clock, reset and apb
   input wire logic mclk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   // events and service
   input wire logic [63:0] chain_event,
   input wire devl_pkg::devl_act_t act_in,
   input wire devl_pkg::devl_svc_t svc_req,
   input wire logic svc_ack
);
   // ****************
   // checks
   // ****************
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (rst);
   logic take;
   logic st_r;
   assign take = psel && penable && !pready;
   // status read whose activity input held still; skews would misfire
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         st_r <= 1'b0;
      else
         st_r <= take && !pwrite && paddr == `DEVL_OFF_STAT
            && act_in == $past(act_in);
   end
   property p_wr;
      st_r && pready && act_in == $past(act_in)
         |-> prdata[`DEVL_ST_WRESP] == act_in.wresp_busy;
   endproperty
   a_wr: assert property (p_wr)
      else $error("write status bit wrong");
   property p_xf;
      st_r && pready && $past(svc_req.valid) && $past(svc_req.valid, 2)
         |-> prdata[`DEVL_ST_XFER];
   endproperty
   a_xf: assert property (p_xf)
      else $error("request active bit low");
   property p_qk;
      st_r && pready && act_in == $past(act_in)
         |-> prdata[`DEVL_ST_QEVT] == act_in.quick_pend;
   endproperty
   a_qk: assert property (p_qk)
      else $error("quick event bit wrong");
   property p_ch;
      |chain_event |-> ##[1:4] svc_req.valid;
   endproperty
   a_ch: assert property (p_ch)
      else $error("chained event not offered");
   property p_hd;
      svc_req.valid && !svc_ack |=> svc_req.valid && $stable(svc_req.chan);
   endproperty
   a_hd: assert property (p_hd)
      else $error("request not held");
   property p_dp;
      svc_req.valid && svc_ack |=> !svc_req.valid;
   endproperty
   a_dp: assert property (p_dp)
      else $error("request not dropped");
   property p_c0;
      take && pwrite && paddr == `DEVL_OFF_CLR_LO && pwdata == 32'h0
         && svc_req.valid && !svc_ack |=> svc_req.valid;
   endproperty
   a_c0: assert property (p_c0)
      else $error("zero clear had effect");
   property p_st;
      take && pwrite && paddr == `DEVL_OFF_SET_LO && pwdata != 32'h0
         |-> ##[1:4] svc_req.valid;
   endproperty
   a_st: assert property (p_st)
      else $error("set event not offered");
endmodule
bind devl_top devl_assertions i_devl_assertions
(
   .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .chain_event(chain_event), .act_in(act_in),
   .svc_req(svc_req), .svc_ack(svc_ack)
);
`default_nettype wire

// file: devl_far.sv
// far-side model: prioritisation logic taking service requests
`timescale 1ns/1ps
`default_nettype none
module devl_far
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // service handshake
   input wire devl_pkg::devl_svc_t svc_req,
   output logic svc_ack,
   // stall control and last channel taken
   input wire logic hold,
   output logic [5:0] last_chan
);
   // ****************
   // acceptor
   // ****************
   // ack only while a request stands; hold stalls it
   assign svc_ack = svc_req.valid && !hold;
   // remember the channel taken at the ack edge
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         last_chan <= 6'h00;
      else if (svc_ack)
         last_chan <= svc_req.chan;
   end
endmodule
`default_nettype wire

// file: devl_top_bench.sv
// self-checking bench for the event latch block
`timescale 1ns/1ps
`default_nettype none
`include "devl_params.svh"
module devl_top_bench;
   // ****************
   // bench
   // ****************
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hold = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [63:0] ext_event = 64'h0, chain_event = 64'h0;
   devl_pkg::devl_act_t act_in = 3'h0;
   devl_pkg::devl_svc_t svc_req;
   logic [31:0] prdata, rd;
   logic [5:0] last_chan;
   logic pready, pslverr, svc_ack, irq, err;
   int error_cnt = 0;
   int n_checks = 0;
   always #2 mclk = ~mclk;
   devl_top i_devl_top (.mclk(mclk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_event(ext_event), .chain_event(chain_event), .act_in(act_in),
      .svc_req(svc_req), .svc_ack(svc_ack), .irq(irq));
   devl_far i_devl_far (.mclk(mclk), .rst(rst), .svc_req(svc_req),
      .svc_ack(svc_ack), .hold(hold), .last_chan(last_chan));
   task automatic chk(input string s, input logic [31:0] v, e);
      n_checks++;
      if (v !== e)
      begin
         error_cnt++;
         $display("Error %s exp %h seen %h", s, e, v);
      end
   endtask
   // apb transfer; ev pulses events at the edge the write lands
   task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [63:0] ev = 64'h0);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      ext_event <= ev;
      do
      begin
         @(posedge mclk);
         ext_event <= 64'h0;
         n++;
      end
      while (!pready && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20)
         error_cnt++;
   endtask
   task automatic pulse(input logic [63:0] ev);
      @(posedge mclk);
      ext_event <= ev;
      @(posedge mclk);
      ext_event <= 64'h0;
   endtask
   task automatic svc(input logic [5:0] c);
      for (int i = 0; i < 40 && last_chan !== c; i++)
         @(posedge mclk);
      chk("svc chan", {26'h0, last_chan}, {26'h0, c});
   endtask
   task automatic irq_is(input logic v);
      repeat (2) @(posedge mclk);
      chk("irq", {31'h0, irq}, {31'h0, v});
   endtask
   task automatic t_regs();
      act_in <= 3'h5;
      bus(1'b1, `DEVL_OFF_LATCH_LO, 32'hffff_ffff);
      bus(1'b0, `DEVL_OFF_LATCH_LO, 32'h0);
      chk("latch ro", rd, 32'h0);
      bus(1'b0, `DEVL_OFF_STAT, 32'h0);
      chk("status", {28'h0, rd[3:0]}, 32'ha);
      act_in <= 3'h2;
      bus(1'b0, `DEVL_OFF_STAT, 32'h0);
      chk("status xfer", {28'h0, rd[3:0]}, 32'h4);
      act_in <= 3'h0;
      bus(1'b0, 12'h004, 32'h0);
      chk("unmapped", {31'h0, err}, 32'h1);
      bus(1'b1, `DEVL_OFF_RAE_LO, 32'h30);
      bus(1'b1, `DEVL_OFF_EN_LO, 32'hf0);
      bus(1'b0, `DEVL_SHADOW_BASE + `DEVL_OFF_EN_LO, 32'h0);
      chk("shadow en", rd, 32'h30);
      bus(1'b1, `DEVL_OFF_EN_LO, 32'h0);
   endtask
   task automatic t_latch();
      pulse(64'h20);
      bus(1'b0, `DEVL_OFF_LATCH_LO, 32'h0);
      chk("latch off", rd, 32'h20);
      chk("idle", {31'h0, svc_req.valid}, 32'h0);
      bus(1'b1, `DEVL_OFF_EN_LO, 32'h20);
      svc(6'h05);
      bus(1'b0, `DEVL_OFF_LATCH_LO, 32'h0);
      chk("serviced", rd, 32'h0);
   endtask
   // stalled far side: second event is lost, miss raises irq
   task automatic t_miss();
      hold <= 1'b1;
      bus(1'b1, `DEVL_OFF_EN_HI, 32'h100);
      pulse(64'h100_0000_0000);
      pulse(64'h100_0000_0000);
      bus(1'b0, `DEVL_OFF_MISS_HI, 32'h0);
      chk("miss hi", rd, 32'h100);
      bus(1'b1, `DEVL_OFF_CLR_LO, 32'h0);
      bus(1'b0, `DEVL_OFF_STAT, 32'h0);
      chk("busy", {31'h0, rd[2]}, 32'h1);
      bus(1'b1, `DEVL_OFF_IEN, 32'h10);
      irq_is(1'b1);
      bus(1'b1, `DEVL_OFF_IEN, 32'h0);
      irq_is(1'b0);
      bus(1'b1, `DEVL_OFF_MCLR_HI, 32'h100);
      bus(1'b0, `DEVL_OFF_MISS_HI, 32'h0);
      chk("miss clr", rd, 32'h0);
      bus(1'b1, `DEVL_OFF_CLR_HI, 32'h100, 64'h100_0000_0000);
      bus(1'b0, `DEVL_OFF_MISS_HI, 32'h0);
      chk("miss lost", rd, 32'h100);
      bus(1'b0, `DEVL_OFF_LATCH_HI, 32'h0);
      chk("latch kept", rd, 32'h100);
      bus(1'b1, `DEVL_OFF_ICLR, 32'h10);
      bus(1'b0, `DEVL_OFF_ISTAT, 32'h0);
      chk("istat clr", {31'h0, rd[4]}, 32'h0);
      bus(1'b1, `DEVL_OFF_IEN, 32'h10);
      irq_is(1'b0);
      hold <= 1'b0;
      svc(6'h28);
   endtask
   task automatic t_clear();
      pulse(64'h8);
      bus(1'b1, `DEVL_OFF_CLR_LO, 32'h0);
      bus(1'b0, `DEVL_OFF_LATCH_LO, 32'h0);
      chk("clr zero", rd, 32'h8);
      bus(1'b1, `DEVL_OFF_CLR_LO, 32'h8);
      bus(1'b0, `DEVL_OFF_LATCH_LO, 32'h0);
      chk("clr one", rd, 32'h0);
      bus(1'b1, `DEVL_OFF_CLR_LO, 32'h8, 64'h8);
      bus(1'b0, `DEVL_OFF_LATCH_LO, 32'h0);
      chk("set wins", rd, 32'h8);
      bus(1'b1, `DEVL_OFF_EN_LO, 32'h8);
      svc(6'h03);
      bus(1'b1, `DEVL_OFF_SET_LO, 32'h4);
      svc(6'h02);
      chain_event <= 64'h1000_0000_0000_0000;
      @(posedge mclk);
      chain_event <= 64'h0;
      svc(6'h3c);
   endtask
   task automatic close_out();
      if (error_cnt == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      t_regs();
      t_latch();
      t_miss();
      t_clear();
      close_out();
   end
   // watchdog well beyond the few hundred cycles the run needs
   initial
   begin
      #20000;
      error_cnt++;
      close_out();
   end
endmodule
`default_nettype wire
